// [src/ltm_pkg.sv]
// ltm_pkg: shared constants and types of the lifetime timer
package ltm_pkg;

  // --------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------
  localparam logic [31:0] ADR_LOAD = 32'hffff0300;
  localparam logic [31:0] ADR_VAL_LO = 32'hffff0304;
  localparam logic [31:0] ADR_VAL_HI = 32'hffff0308;
  localparam logic [31:0] ADR_CTRL = 32'hffff030c;
  localparam logic [31:0] ADR_CLR = 32'hffff0310;
  localparam logic [31:0] ADR_CAP = 32'hffff0314;

  // --------------------------------------------------------------
  // widths, masks and reset values
  // --------------------------------------------------------------
  localparam int CNT_W = 48;
  localparam int LO_W = 16;
  localparam int HI_W = 32;
  localparam int CTRL_W = 18;
  localparam int SRC_N = 18;
  localparam int PRE_W = 15;
  localparam logic [17:0] CTRL_MASK = 18'h3f7df;
  localparam logic [17:0] SRC_VALID = 18'h3dfef;
  localparam logic [17:0] CTRL_RST = 18'h00000;
  localparam logic [15:0] LOAD_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [47:0] CNT_RST = 48'h000000000000;
  localparam logic [47:0] FS_48 = 48'hffffffffffff;
  localparam logic [47:0] FS_16 = 48'h00000000ffff;

  // --------------------------------------------------------------
  // clock source and prescaler codes
  // --------------------------------------------------------------
  localparam logic [1:0] CLK_CORE = 2'h0;
  localparam logic [1:0] CLK_LPOSC = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;
  localparam logic [1:0] CLK_PREC = 2'h3;
  localparam logic [3:0] PRE_DIV1 = 4'h0;
  localparam logic [3:0] PRE_DIV16 = 4'h4;
  localparam logic [3:0] PRE_DIV256 = 4'h8;
  localparam logic [3:0] PRE_DIV32K = 4'hf;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic capEn;
    logic [4:0] capSel;
    logic rsv11;
    logic [1:0] clkSel;
    logic countUp;
    logic enable;
    logic periodic;
    logic rsv5;
    logic mode48;
    logic [3:0] prescale;
  } ltm_ctrl_t;

  typedef struct packed {
    ltm_ctrl_t ctrl;
    logic [15:0] load;
    logic start;
    logic reload;
  } ltm_stage_t;

  typedef enum logic [0:0] {
    RUN_IDLE = 1'b0,
    RUN_COUNT = 1'b1
  } ltm_run_t;

endpackage : ltm_pkg

// [src/ltm_tick_gen.sv]
// ltm_tick_gen: clock source selection and prescaler for the timer
`timescale 1ns/1ps
module ltm_tick_gen
  import ltm_pkg::*;
#(
  parameter int PRE_BITS = PRE_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // 32.768 kHz source pins
  input wire logic oscLowPower,
  input wire logic oscXtal,
  input wire logic oscPrecision,
  // selection
  input wire logic [1:0] clkSel,
  input wire logic [3:0] preCode,
  // ticks
  output logic srcTick,
  output logic cntTick
);

  if (PRE_BITS < PRE_W) begin : g_chk
    $error("prescaler counter too narrow for divide by 32768");
  end

  // --------------------------------------------------------------
  // pin synchronisers and rising edge detect
  // --------------------------------------------------------------
  logic [2:0] pinRaw;
  logic [2:0] edgeSeen;
  assign pinRaw = {oscPrecision, oscXtal, oscLowPower};

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_pin
    logic meta;
    logic stable;
    logic prev;
    // edge taken from the second and third flops, never from meta
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        meta <= 1'b0;
        stable <= 1'b0;
        prev <= 1'b0;
      end else if (clkEn) begin
        meta <= pinRaw[gi];
        stable <= meta;
        prev <= stable;
      end
    end
    assign edgeSeen[gi] = stable & ~prev;
  end

  // core clock ticks every cycle, slow sources once per rising edge
  assign srcTick = (clkSel == CLK_CORE) ? 1'b1 : edgeSeen[clkSel - 2'h1];

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  logic [PRE_BITS-1:0] preCnt;
  logic [PRE_BITS-1:0] preMask;
  logic [3:0] preExp;

  // undefined codes fall back to divide by one
  assign preExp = (preCode == PRE_DIV16) ? 4'h4 :
                  (preCode == PRE_DIV256) ? 4'h8 :
                  (preCode == PRE_DIV32K) ? 4'hf : 4'h0;
  assign preMask = PRE_BITS'((32'h1 << preExp) - 32'h1);
  assign cntTick = srcTick & ((preCnt & preMask) == preMask);

  // free running divider; a new ratio applies at once, without a restart of the count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      preCnt <= '0;
    end else if (clkEn && srcTick) begin
      preCnt <= preCnt + PRE_BITS'(1);
    end
  end

endmodule : ltm_tick_gen

// [src/ltm_timer.sv]
// ltm_timer: lifetime timer with wishbone registers and capture
`timescale 1ns/1ps
module ltm_timer
  import ltm_pkg::*;
#(
  parameter int EVT_N = SRC_N
) (
  // clock, reset and freeze
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // slow clock source pins
  input wire logic oscLowPower,
  input wire logic oscXtal,
  input wire logic oscPrecision,
  // interrupt lines of the system, same clock
  input wire logic [EVT_N-1:0] eventLines,
  // timer interrupt
  output logic timerIrq
);

  if (EVT_N != SRC_N) begin : g_chk
    $error("capture source count must be eighteen");
  end

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  function automatic logic [31:0] byteMask(input logic [3:0] sel);
    byteMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : byteMask

  logic busReq;
  logic busAsk;
  logic wrStrobe;
  logic hitLoad;
  logic hitLo;
  logic hitHi;
  logic hitCtrl;
  logic hitClr;
  logic hitCap;
  logic [31:0] wrMask;

  assign busReq = cyc_i & stb_i;
  assign busAsk = busReq & ~ack_o;
  // writes land on the edge where the master sees ack
  assign wrStrobe = busReq & we_i & ack_o;
  assign hitLoad = (adr_i == ADR_LOAD);
  assign hitLo = (adr_i == ADR_VAL_LO);
  assign hitHi = (adr_i == ADR_VAL_HI);
  assign hitCtrl = (adr_i == ADR_CTRL);
  assign hitClr = (adr_i == ADR_CLR);
  assign hitCap = (adr_i == ADR_CAP);
  assign wrMask = byteMask(sel_i);

  // --------------------------------------------------------------
  // software side registers, core clock
  // --------------------------------------------------------------
  ltm_ctrl_t ctrlShadow;
  logic [15:0] loadShadow;
  logic startPend;
  logic reloadPend;
  logic [31:0] ctrlMerged;
  logic [31:0] loadMerged;
  logic [31:0] capMerged;
  logic srcTick;
  logic cntTick;
  logic wrCtrl;
  logic wrLoad;
  logic wrClr;

  assign ctrlMerged = (dat_i & wrMask) |
                      ({14'h0, ctrlShadow} & ~wrMask);
  assign loadMerged = (dat_i & wrMask) | ({16'h0, loadShadow} & ~wrMask);
  assign wrCtrl = wrStrobe & hitCtrl;
  // load and clear are dead while the counter is in 48-bit mode
  assign wrLoad = wrStrobe & hitLoad & ~ctrlShadow.mode48;
  assign wrClr = wrStrobe & hitClr & ~ctrlShadow.mode48;

  // control write raises a start request that waits for the timer clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrlShadow <= ltm_ctrl_t'(CTRL_RST);
      loadShadow <= LOAD_RST;
      startPend <= 1'b0;
      reloadPend <= 1'b0;
    end else if (clkEn) begin
      if (wrCtrl) begin
        ctrlShadow <= ltm_ctrl_t'(ctrlMerged[17:0] & CTRL_MASK);
      end
      if (wrLoad) begin
        loadShadow <= loadMerged[15:0];
      end
      // a new write wins over the hand-off in the same cycle
      startPend <= wrCtrl | (startPend & ~srcTick);
      reloadPend <= wrClr | (reloadPend & ~srcTick);
    end
  end

  // --------------------------------------------------------------
  // two stage hand-off into the timer clock
  // --------------------------------------------------------------
  ltm_stage_t stage1;
  ltm_stage_t stage2;
  ltm_stage_t stageIn;

  assign stageIn = '{ctrl: ctrlShadow, load: loadShadow,
                     start: startPend, reload: reloadPend};

  // both stages advance only on ticks of the selected source, so the
  // counter sees new settings, bar the clock select taken straight from ctrlShadow, no sooner than two of its periods
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else if (clkEn && srcTick) begin
      stage1 <= stageIn;
      stage2 <= stage1;
    end
  end

  // --------------------------------------------------------------
  // clock source and prescaler
  // --------------------------------------------------------------
  ltm_tick_gen u_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .oscLowPower(oscLowPower),
    .oscXtal(oscXtal),
    .oscPrecision(oscPrecision),
    .clkSel(ctrlShadow.clkSel),
    .preCode(stage2.ctrl.prescale),
    .srcTick(srcTick),
    .cntTick(cntTick)
  );

  // --------------------------------------------------------------
  // run state
  // --------------------------------------------------------------
  ltm_run_t runState;
  ltm_run_t next_runState;
  logic startNow;
  logic reloadNow;

  assign startNow = srcTick & stage2.start;
  assign reloadNow = srcTick & stage2.reload & ~stage2.ctrl.mode48;

  always_comb begin
    next_runState = runState;
    case (runState)
      RUN_IDLE: begin
        if (startNow && stage2.ctrl.enable) begin
          next_runState = RUN_COUNT;
        end
      end
      RUN_COUNT: begin
        if (srcTick && !stage2.ctrl.enable) begin
          next_runState = RUN_IDLE;
        end
      end
      default: begin
        next_runState = RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      runState <= RUN_IDLE;
    end else if (clkEn) begin
      runState <= next_runState;
    end
  end

  // --------------------------------------------------------------
  // counter datapath
  // --------------------------------------------------------------
  logic [47:0] count;
  logic [47:0] next_count;
  logic [47:0] fullScale;
  logic [47:0] stepped;
  logic [47:0] startVal;
  logic [47:0] termVal;
  logic countUp;
  logic atTerm;
  logic stepNow;
  logic setIrq;
  logic clrIrq;

  // 48-bit mode ignores the direction bit and the load register
  assign countUp = stage2.ctrl.mode48 | stage2.ctrl.countUp;
  assign fullScale = stage2.ctrl.mode48 ? FS_48 : FS_16;
  assign startVal = stage2.ctrl.mode48 ? CNT_RST :
                    {32'h0, stage2.load};
  assign termVal = countUp ? fullScale : CNT_RST;
  assign atTerm = (count == termVal);
  // the natural wrap is the free-running rollover
  assign stepped = (countUp ? count + 48'h1 : count - 48'h1) &
                   fullScale;
  assign stepNow = cntTick & (runState == RUN_COUNT) & ~startNow &
                   ~reloadNow;
  assign setIrq = stepNow & (stepped == termVal);
  assign clrIrq = wrClr;

  // start and clear-reload come first, then the counting step
  always_comb begin
    next_count = count;
    if (startNow || reloadNow) begin
      next_count = startVal;
    end else if (stepNow) begin
      if (atTerm && stage2.ctrl.periodic) begin
        next_count = startVal;
      end else begin
        next_count = stepped;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= CNT_RST;
    end else if (clkEn) begin
      count <= next_count;
    end
  end

  // a terminal count in the clear cycle keeps the flag set
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timerIrq <= 1'b0;
    end else if (clkEn) begin
      timerIrq <= setIrq | (timerIrq & ~clrIrq);
    end
  end

  // --------------------------------------------------------------
  // event capture
  // --------------------------------------------------------------
  logic [15:0] capture;
  logic [EVT_N-1:0] evtValid;
  logic evtSel;
  logic evtPrev;
  logic capHit;

  assign evtValid = eventLines & SRC_VALID;
  assign evtSel = (ctrlShadow.capSel < 5'd18) ?
                  evtValid[ctrlShadow.capSel] : 1'b0;
  assign capHit = evtSel & ~evtPrev & ctrlShadow.capEn &
                  ~ctrlShadow.mode48;
  assign capMerged = (dat_i & wrMask) | ({16'h0, capture} & ~wrMask);

  // the event beats a software write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evtPrev <= 1'b0;
      capture <= CAP_RST;
    end else if (clkEn) begin
      evtPrev <= evtSel;
      if (capHit) begin
        capture <= count[15:0];
      end else if (wrStrobe && hitCap && !ctrlShadow.mode48) begin
        capture <= capMerged[15:0];
      end
    end
  end

  // --------------------------------------------------------------
  // read path and acknowledge
  // --------------------------------------------------------------
  logic [31:0] rdData;

  // value reads only look at the count, they never touch it
  assign rdData = hitLo ? {16'h0, count[15:0]} :
                  hitHi ? count[47:16] :
                  hitCtrl ? {14'h0, ctrlShadow} :
                  hitCap ? {16'h0, capture} : 32'h0;

  // one cycle answer for every address, unmapped ones read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (clkEn) begin
      ack_o <= busAsk;
      if (busAsk) begin
        dat_o <= rdData;
      end
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_ask;
    clkEn && busAsk;
  endsequence

  sequence s_ctrlWrite;
    clkEn && wrCtrl;
  endsequence

  property p_ack_fast;
    s_ask |=> ack_o;
  endproperty
  a_ack_fast: assert property (p_ack_fast)
    else $error("no ack one cycle after request");

  property p_ack_drop;
    clkEn && ack_o |=> !ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack held for more than one cycle");

  property p_read_lo;
    clkEn && busAsk && !we_i && hitLo && !(startNow || stepNow || reloadNow)
      |=> dat_o == {16'h0, count[15:0]};
  endproperty
  a_read_lo: assert property (p_read_lo)
    else $error("low value read does not match count");

  property p_irq_set;
    clkEn && setIrq |=> timerIrq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("terminal count did not raise interrupt");

  property p_irq_clr;
    clkEn && clrIrq && !setIrq |=> !timerIrq;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("clear write left interrupt pending");

  property p_start_pend;
    s_ctrlWrite |=> startPend;
  endproperty
  a_start_pend: assert property (p_start_pend)
    else $error("control write raised no start request");

  property p_sync_two;
    clkEn && srcTick && stage1.start |=> stage2.start;
  endproperty
  a_sync_two: assert property (p_sync_two)
    else $error("start did not reach second stage");

  property p_no_early;
    clkEn && srcTick && !stage1.start |=> !stage2.start;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("start skipped the first stage");

  property p_start_load;
    clkEn && (startNow || reloadNow) |=> count == $past(startVal);
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start or clear did not load the counter");

  property p_periodic;
    clkEn && stepNow && atTerm && stage2.ctrl.periodic
      |=> count == $past(startVal);
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic mode did not reload");

  property p_free;
    clkEn && stepNow && !stage2.ctrl.periodic
      |=> count == $past(stepped);
  endproperty
  a_free: assert property (p_free)
    else $error("free running step wrong");

  property p_capture;
    clkEn && capHit |=> capture == $past(count[15:0]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy the count");

endmodule : ltm_timer

// [verification/ltm_timer_bench.sv]
// ltm_timer_bench: self-checking bench of the lifetime timer
`timescale 1ns/1ps
module ltm_timer_bench
  import ltm_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk_sys;
  logic reset_n;
  logic clkEn;
  logic cyc, stb, we, ack, timerIrq;
  logic [31:0] adr, datI, datO;
  logic [3:0] sel;
  logic [2:0] oscPins;
  logic [17:0] evt;
  int err_count;
  int compares;

  ltm_timer #(.EVT_N(18)) ltm_timer_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .oscLowPower(oscPins[0]), .oscXtal(oscPins[1]),
    .oscPrecision(oscPins[2]), .eventLines(evt), .timerIrq(timerIrq)
  );

  // free-running 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // one classic cycle; the request stays put until ack is sampled
  task automatic wbXfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1); // a missing ack is left to the watchdog
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("ack latency", 48'(n), 48'h2);
  endtask : wbXfer

  task automatic wbWrite(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(a, 1'b1, d, q);
  endtask : wbWrite

  task automatic wbRead(input logic [31:0] a, output logic [31:0] q);
    wbXfer(a, 1'b0, 32'h0, q);
  endtask : wbRead

  task automatic waitIrq(input int bound);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (timerIrq !== 1'b1 && n < bound);
  endtask : waitIrq

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset values, read-only places, reserved control bits, hole
  task automatic regsAfterReset();
    logic [31:0] v;
    wbWrite(ADR_VAL_LO, 32'h1234);
    wbRead(ADR_VAL_LO, v);
    check("value low", 48'(v), 48'h0);
    wbRead(ADR_VAL_HI, v);
    check("value high", 48'(v), 48'h0);
    wbRead(ADR_CAP, v);
    check("capture", 48'(v), 48'h0);
    wbRead(32'hffff0318, v);
    check("unmapped", 48'(v), 48'h0);
    wbWrite(ADR_CTRL, 32'hffffff7f);
    wbRead(ADR_CTRL, v);
    check("control mask", 48'(v), 48'h3f75f);
    wbWrite(ADR_CTRL, 32'h0); // halt while the irq is unwatched
  endtask : regsAfterReset

  // 16-bit run at /16 from load, terminal count, then reload or wrap
  task automatic run16(input logic [15:0] ld, input logic up,
                       input logic per);
    logic [31:0] v;
    logic [15:0] term, after;
    term = up ? 16'hffff : 16'h0000;
    after = per ? ld : (up ? 16'h0000 : 16'hffff);
    wbWrite(ADR_LOAD, {16'h0, ld}); // callers never pass zero
    wbWrite(ADR_CTRL, {23'h0, up, 1'b1, per, 6'h04});
    repeat (5) @(posedge clk_sys); // more than three ticks
    wbWrite(ADR_CLR, 32'h0); // stray irq cleared with 0x00
    @(posedge clk_sys);
    check("irq after clear", 48'(timerIrq), 48'h0);
    waitIrq(400);
    check("irq raised", 48'(timerIrq), 48'h1);
    wbRead(ADR_VAL_LO, v);
    check("terminal count", v, {32'h0, term});
    repeat (16) @(posedge clk_sys);
    wbRead(ADR_VAL_LO, v);
    check("after terminal", v, {32'h0, after});
  endtask : run16

  // 48-bit run on a chosen source and prescale, count kept in range
  task automatic run48(input logic [3:0] pre, input logic [1:0] src,
                       input int lo, input int hi);
    logic [31:0] v;
    wbWrite(ADR_CTRL, {21'h0, src, 5'b01001, pre});
    if (src == 2'h0) repeat (2000) @(posedge clk_sys);
    else repeat (20) begin
      repeat (4) @(posedge clk_sys);
      oscPins[src - 2'h1] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      oscPins[src - 2'h1] <= 1'b0;
    end
    wbRead(ADR_VAL_LO, v);
    check("count in range", 48'(v >= lo && v <= hi), 48'h1);
    wbRead(ADR_VAL_HI, v);
    check("high word", 48'(v), 48'h0);
  endtask : run48

  // 48-bit mode: undisturbed reads, capture and clear writes ignored
  task automatic mode48Limits();
    logic [31:0] a, b, c;
    wbWrite(ADR_CTRL, 32'h00000090);
    repeat (10) @(posedge clk_sys);
    wbRead(ADR_VAL_LO, a);
    wbRead(ADR_VAL_LO, b);
    check("read spacing", 48'(b - a), 48'h3);
    wbWrite(ADR_CAP, 32'h1234);
    wbRead(ADR_CAP, c);
    check("capture write", 48'(c), 48'h0);
    wbWrite(ADR_CLR, 32'h0);
    repeat (6) @(posedge clk_sys);
    wbRead(ADR_VAL_LO, c);
    check("clear ignored", 48'(c > b + 32'h8), 48'h1);
  endtask : mode48Limits

  // clock enable low freezes the running count, so the reads sit 3 apart
  task automatic freezeHold();
    logic [31:0] a, b;
    wbRead(ADR_VAL_LO, a);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    clkEn <= 1'b1;
    wbRead(ADR_VAL_LO, b);
    check("frozen count", 48'(b - a), 48'h3);
  endtask : freezeHold

  // capture on source 1, then a reserved index that must not capture
  task automatic captureEvent();
    logic [31:0] c, v, k;
    wbWrite(ADR_CTRL, 32'h0); // leave 48-bit mode so the load lands
    wbWrite(ADR_LOAD, 32'h0100);
    wbWrite(ADR_CTRL, {14'h0, 1'b1, 5'd1, 8'b00011000, 4'h8});
    repeat (600) @(posedge clk_sys);
    evt[1] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    evt[1] <= 1'b0;
    wbRead(ADR_CAP, c);
    wbRead(ADR_VAL_LO, v);
    check("capture", 48'(v - c <= 1 && c > 32'h0100), 48'h1);
    wbWrite(ADR_CTRL, {14'h0, 1'b1, 5'd4, 8'b00011000, 4'h8});
    repeat (300) @(posedge clk_sys);
    evt[4] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    evt[4] <= 1'b0;
    wbRead(ADR_CAP, k);
    check("reserved source", 48'(k), {32'h0, c[15:0]});
  endtask : captureEvent

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 32'h0;
    datI = 32'h0;
    sel = 4'h0;
    oscPins = 3'h0;
    evt = 18'h0;
    err_count = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    regsAfterReset();
    run16(16'h0003, 1'b0, 1'b1);
    run16(16'h0003, 1'b0, 1'b0);
    run16(16'hfffc, 1'b1, 1'b1);
    run16(16'hfffc, 1'b1, 1'b0);
    mode48Limits();
    freezeHold();
    run48(PRE_DIV1, CLK_CORE, 1990, 2010);
    run48(PRE_DIV16, CLK_CORE, 124, 126);
    run48(PRE_DIV256, CLK_CORE, 6, 8);
    run48(PRE_DIV32K, CLK_CORE, 0, 0);
    run48(PRE_DIV1, CLK_LPOSC, 14, 20);
    run48(PRE_DIV1, CLK_XTAL, 14, 20);
    run48(PRE_DIV1, CLK_PREC, 14, 20);
    captureEvent();
    report_and_stop();
  end

  // the whole run needs some 10000 cycles; six times that is a hang
  initial begin
    #(60000 * 20);
    err_count++;
    report_and_stop();
  end

endmodule : ltm_timer_bench
